// file: pkg/stfr_consts.svh
`ifndef STFR_CONSTS_SVH
`define STFR_CONSTS_SVH

// Register byte offsets
`define STFR_OFF_INT_STATUS3 8'h1f
`define STFR_OFF_TEMP_LO 8'h20
`define STFR_OFF_TEMP_HI 8'h21
`define STFR_OFF_FILL_LO 8'h22
`define STFR_OFF_FILL_HI 8'h23
`define STFR_OFF_FIFO_DATA 8'h24
`define STFR_OFF_CMD 8'h7e

// Command code that flushes the FIFO (arbitrary value)
`define STFR_CMD_FIFO_FLUSH 8'ha5

// Status byte field positions
`define STFR_BIT_FLAT 7
`define STFR_BIT_ORIENT_Z 6
`define STFR_BIT_ORIENT_XY_HI 5
`define STFR_BIT_ORIENT_XY_LO 4
`define STFR_BIT_HIGH_SIGN 3
`define STFR_BIT_HIGH_Z 2
`define STFR_BIT_HIGH_Y 1
`define STFR_BIT_HIGH_X 0

// Temperature codes
`define STFR_TEMP_INVALID 16'h8000
`define STFR_TEMP_RESET 16'h8000

// FIFO geometry
`define STFR_FIFO_DEPTH 1024
`define STFR_FIFO_AW 10
`define STFR_SKIP_FRAME_BYTES 11'h002
`define STFR_FIFO_EMPTY_BYTE 8'h80

// Timing
`define STFR_CLK_KHZ 100000
`define STFR_TEMP_FAST_MS 10
`define STFR_TEMP_SLOW_MS 1280
`define STFR_TEMP_FAST_CYC (`STFR_TEMP_FAST_MS * `STFR_CLK_KHZ)
`define STFR_TEMP_SLOW_CYC (`STFR_TEMP_SLOW_MS * `STFR_CLK_KHZ)

`endif

// file: pkg/stfr_pkg.sv
package stfr_pkg;
	typedef enum logic [1:0] {
		STFR_PMU_SUSPEND = 2'b00,
		STFR_PMU_NORMAL = 2'b01,
		STFR_PMU_RSVD = 2'b10,
		STFR_PMU_FASTUP = 2'b11
	} stfr_pmu_e;
	typedef logic [10:0] stfr_ptr_t;
endpackage : stfr_pkg

// file: logic/stfr_regs.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "stfr_consts.svh"

// Function
// - Bit 7 shows flat position
// - Bit 6 gives z orientation
// - Bits 5:4 give x-y orientation code
// - Orientation tracks live, frozen while blocked
// - Bit 3 captures high-g sign
// - Bits 2:0 flag high-g trigger axes
// - Temperature off when all sensors suspend
// - Temperature valid only in gyro normal mode
// - Signed word, 0x8000 means invalid
// - Refresh every 10 ms in normal
// - Refresh every 1.28 s otherwise
// - Counter gives fill bytes, skip frame included
// - Empty FIFO reads count zero
// - Counter clears on drain or flush command
// - Counter changes at frame boundaries and when a frame starts to drop
// - Data port address never increments
// - Partly read frame resent whole next time
// - Port bytes follow configured frame format
// - FIFO reads leave new-data flag alone
module stfr_regs import stfr_pkg::*; #(
	parameter int TEMP_FAST_CYC = `STFR_TEMP_FAST_CYC,
	parameter int TEMP_SLOW_CYC = `STFR_TEMP_SLOW_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// End of a host read burst
	input wire logic burst_end,
	// Orientation and flat engine
	input wire logic flat_now,
	input wire logic flat_int_en,
	input wire logic [2:0] orient_now,
	input wire logic orient_block,
	// High-g engine
	input wire logic highg_trig,
	input wire logic highg_sign,
	input wire logic [2:0] highg_axes,
	// Power state and temperature sensor
	input wire logic all_suspend,
	input wire logic [1:0] gyr_pmu_status,
	input wire logic [15:0] temp_sample,
	output logic temp_valid,
	// Frame writer, already formatted
	input wire logic fifo_wr_valid,
	input wire logic [7:0] fifo_wr_data,
	input wire logic fifo_wr_last,
	output logic fifo_overflow
);

	logic [7:0] fifo_mem [`STFR_FIFO_DEPTH];
	logic fifo_eof [`STFR_FIFO_DEPTH];
	stfr_ptr_t wptr_r;
	stfr_ptr_t wcommit_r;
	stfr_ptr_t rptr_r;
	stfr_ptr_t rcommit_r;
	stfr_ptr_t fill_r;
	logic skip_r;
	logic flat_r;
	logic [2:0] orient_r;
	logic high_sign_r;
	logic [2:0] high_axes_r;
	logic [15:0] temp_r;
	logic [26:0] temp_cnt_r;
	logic [26:0] temp_lim;
	logic [7:0] status_byte;
	logic [7:0] rdata_nxt;
	logic flush;
	logic data_rd;
	logic data_avail;
	logic wr_fits;
	stfr_ptr_t used;

	assign flush = reg_wr && reg_addr == `STFR_OFF_CMD && reg_wdata == `STFR_CMD_FIFO_FLUSH;
	assign data_avail = rptr_r != wcommit_r;
	assign data_rd = reg_rd && reg_addr == `STFR_OFF_FIFO_DATA && data_avail;
	assign used = stfr_ptr_t'(wptr_r - rcommit_r);
	assign wr_fits = used < stfr_ptr_t'(`STFR_FIFO_DEPTH);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flat_r <= 1'b0;
		end else begin
			flat_r <= flat_now && flat_int_en;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			orient_r <= 3'h0;
		end else if (!orient_block) begin
			orient_r <= orient_now;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			high_sign_r <= 1'b0;
			high_axes_r <= 3'h0;
		end else if (highg_trig) begin
			high_sign_r <= highg_sign;
			high_axes_r <= highg_axes;
		end
	end

	always_comb begin
		status_byte = 8'h00;
		status_byte[`STFR_BIT_FLAT] = flat_r;
		status_byte[`STFR_BIT_ORIENT_Z] = orient_r[2];
		status_byte[`STFR_BIT_ORIENT_XY_HI] = orient_r[1];
		status_byte[`STFR_BIT_ORIENT_XY_LO] = orient_r[0];
		status_byte[`STFR_BIT_HIGH_SIGN] = high_sign_r;
		status_byte[`STFR_BIT_HIGH_Z] = high_axes_r[2];
		status_byte[`STFR_BIT_HIGH_Y] = high_axes_r[1];
		status_byte[`STFR_BIT_HIGH_X] = high_axes_r[0];
	end

	assign temp_lim = (gyr_pmu_status == STFR_PMU_NORMAL) ?
		27'(TEMP_FAST_CYC - 1) : 27'(TEMP_SLOW_CYC - 1);

	// Count runs on across a mode change; a shorter limit fires at once
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			temp_cnt_r <= 27'h0;
		end else if (all_suspend || temp_cnt_r >= temp_lim) begin
			temp_cnt_r <= 27'h0;
		end else begin
			temp_cnt_r <= temp_cnt_r + 27'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			temp_r <= `STFR_TEMP_RESET;
		end else if (all_suspend) begin
			temp_r <= `STFR_TEMP_INVALID;
		end else if (temp_cnt_r >= temp_lim) begin
			temp_r <= temp_sample;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			temp_valid <= 1'b0;
		end else begin
			temp_valid <= !all_suspend && gyr_pmu_status == STFR_PMU_NORMAL &&
				temp_r != `STFR_TEMP_INVALID;
		end
	end

	always_ff @(posedge clk) begin
		if (fifo_wr_valid && wr_fits && !skip_r) begin
			fifo_mem[wptr_r[`STFR_FIFO_AW-1:0]] <= fifo_wr_data;
			fifo_eof[wptr_r[`STFR_FIFO_AW-1:0]] <= fifo_wr_last;
		end
	end

	// Write side; a frame that does not fit is dropped whole
	always_ff @(posedge clk) begin
		if (!rst_n || flush) begin
			wptr_r <= 11'h000;
			wcommit_r <= 11'h000;
			skip_r <= 1'b0;
		end else if (fifo_wr_valid) begin
			if (!wr_fits || skip_r) begin
				wptr_r <= wcommit_r;
				skip_r <= !fifo_wr_last || wcommit_r != rcommit_r;
			end else begin
				wptr_r <= wptr_r + 11'h001;
				if (fifo_wr_last) begin
					wcommit_r <= wptr_r + 11'h001;
				end
			end
		end else if (skip_r && wcommit_r == rcommit_r) begin
			skip_r <= 1'b0;
		end
	end

	// Read side
	always_ff @(posedge clk) begin
		if (!rst_n || flush) begin
			rptr_r <= 11'h000;
			rcommit_r <= 11'h000;
		end else if (data_rd) begin
			rptr_r <= rptr_r + 11'h001;
			if (fifo_eof[rptr_r[`STFR_FIFO_AW-1:0]]) begin
				rcommit_r <= rptr_r + 11'h001;
			end
		end else if (burst_end) begin
			rptr_r <= rcommit_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || flush) begin
			fill_r <= 11'h000;
		end else if (wcommit_r == rcommit_r) begin
			fill_r <= 11'h000;
		end else begin
			fill_r <= stfr_ptr_t'(wcommit_r - rcommit_r) +
				(skip_r ? `STFR_SKIP_FRAME_BYTES : 11'h000);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || flush) begin
			fifo_overflow <= 1'b0;
		end else begin
			fifo_overflow <= skip_r;
		end
	end

	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`STFR_OFF_INT_STATUS3: rdata_nxt = status_byte;
				`STFR_OFF_TEMP_LO: rdata_nxt = temp_r[7:0];
				`STFR_OFF_TEMP_HI: rdata_nxt = temp_r[15:8];
				`STFR_OFF_FILL_LO: rdata_nxt = fill_r[7:0];
				`STFR_OFF_FILL_HI: rdata_nxt = {5'h00, fill_r[10:8]};
				`STFR_OFF_FIFO_DATA: begin
					rdata_nxt = data_avail ?
						fifo_mem[rptr_r[`STFR_FIFO_AW-1:0]] : `STFR_FIFO_EMPTY_BYTE;
				end
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= rdata_nxt;
		end
	end

endmodule : stfr_regs

// file: test/stfr_regs_asserts.sv
`timescale 1ns/1ps
module stfr_regs_asserts import stfr_pkg::*; (
	// Clock, reset and register port
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Engines and power
	input wire logic flat_now,
	input wire logic flat_int_en,
	input wire logic [2:0] orient_now,
	input wire logic orient_block,
	input wire logic highg_trig,
	input wire logic highg_sign,
	input wire logic [2:0] highg_axes,
	input wire logic all_suspend,
	input wire logic [1:0] gyr_pmu_status,
	input wire logic temp_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire st = reg_rd && reg_addr == 8'h1f;
	// Three stable cycles cover the status flop and the read flop
	a_flat_set: assert property ((flat_now && flat_int_en)[*3] ##0 st |=> reg_rdata[7])
		else $error("flat bit not set");
	a_flat_gate: assert property ((!flat_int_en)[*3] ##0 st |=> !reg_rdata[7])
		else $error("flat bit set while disabled");
	a_orient_live: assert property (
		(!orient_block && $stable(orient_now))[*3] ##0 st |=>
		reg_rdata[6:4] == $past(orient_now))
		else $error("orientation not tracked");
	a_orient_hold: assert property (
		orient_block[*3] ##0 st ##1 st && orient_block |=>
		reg_rdata[6:4] == $past(reg_rdata[6:4]))
		else $error("orientation moved while blocked");
	// Trigger, three quiet cycles, read in the third: detail comes from the trigger cycle
	a_highg_cap: assert property (
		highg_trig ##1 (!highg_trig)[*3] ##0 st |=>
		reg_rdata[3:0] == {$past(highg_sign, 4), $past(highg_axes, 4)})
		else $error("high-g detail wrong");
	a_temp_off: assert property (
		all_suspend[*3] ##0 reg_rd && reg_addr == 8'h21 |=> reg_rdata == 8'h80)
		else $error("temperature not invalid in suspend");
	a_temp_valid: assert property (
		temp_valid |-> $past(gyr_pmu_status) == STFR_PMU_NORMAL && !$past(all_suspend))
		else $error("temperature valid outside normal mode");
	a_flush_clear: assert property (
		reg_wr && reg_addr == 8'h7e && reg_wdata == 8'ha5 ##1
		reg_rd && reg_addr == 8'h22 |=> reg_rdata == 8'h00)
		else $error("fill not cleared by flush");
endmodule : stfr_regs_asserts

bind stfr_regs stfr_regs_asserts chk (.*);

// file: test/stfr_host.sv
`timescale 1ns/1ps
module stfr_host (
	// Clock and read data
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	// Register requests
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic burst_end
);
	logic [7:0] q[$];
	initial {reg_addr, reg_wdata, reg_wr, reg_rd, burst_end} = '0;
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input int n);
		q = {};
		reg_addr <= a;
		reg_rd <= 1'b1;
		for (int i = 0; i <= n; i++) begin
			@(posedge clk);
			if (i > 0)
				q.push_back(reg_rdata);
			if (i == n - 1)
				reg_rd <= 1'b0;
		end
	endtask : rd
	task be();
		burst_end <= 1'b1;
		@(posedge clk);
		burst_end <= 1'b0;
	endtask : be
endmodule : stfr_host

// file: test/stfr_regs_tb.sv
`timescale 1ns/1ps
module stfr_regs_tb import stfr_pkg::*; ;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, fifo_wr_data;
	logic reg_wr, reg_rd, burst_end, flat_now, flat_int_en, orient_block, highg_trig;
	logic highg_sign, all_suspend, temp_valid, fifo_wr_valid, fifo_wr_last, fifo_overflow;
	logic [2:0] orient_now, highg_axes;
	logic [1:0] gyr_pmu_status;
	logic [15:0] temp_sample, t;
	logic [7:0] fb[$];
	int fails = 0;
	int num_checks = 0;
	always #5 clk = ~clk;
	stfr_regs #(.TEMP_FAST_CYC(20), .TEMP_SLOW_CYC(50)) dut (.*);
	stfr_host h (.*);
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task print_verdict();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task tk(input int n);
		repeat (n) @(posedge clk);
	endtask : tk
	task rdw(input logic [7:0] a, output logic [15:0] v);
		h.rd(a, 1);
		v[7:0] = h.q[0];
		h.rd(a + 8'h1, 1);
		v[15:8] = h.q[0];
	endtask : rdw
	// Pauses after the first byte to look at the fill mid-frame
	task frame(input int n, input logic [15:0] pre);
		for (int i = 0; i < n; i++) begin
			t[7:0] = 8'($urandom);
			fb.push_back(t[7:0]);
			fifo_wr_data <= t[7:0];
			fifo_wr_valid <= 1'b1;
			fifo_wr_last <= i == n - 1;
			tk(1);
			if (i == 0) begin
				fifo_wr_valid <= 1'b0;
				rdw(8'h22, t);
				chk("mid", pre, t);
			end
		end
		fifo_wr_valid <= 1'b0;
	endtask : frame
	initial begin
		{flat_now, flat_int_en, orient_block, highg_trig, highg_sign, all_suspend} = '0;
		{fifo_wr_valid, fifo_wr_last, fifo_wr_data, orient_now, highg_axes} = '0;
		{gyr_pmu_status, temp_sample} = '0;
		void'($urandom(32'hee724628));
		tk(12);
		rst_n <= 1'b1;
		tk(1);
		for (int i = 0; i < 8; i++) begin
			t = 16'($urandom);
			if (i < 2)
				t[1:0] = i[0] ? 2'b01 : 2'b11;
			{flat_now, flat_int_en} <= t[1:0];
			orient_now <= i[2:0];
			{highg_sign, highg_axes} <= t[5:2];
			highg_trig <= 1'b1;
			tk(1);
			highg_trig <= 1'b0;
			tk(2);
			h.rd(8'h1f, 1);
			chk("status", {t[1] & t[0], i[2:0], t[5:2]}, h.q[0]);
		end
		orient_block <= 1'b1;
		tk(1);
		orient_now <= 3'h2;
		tk(3);
		h.rd(8'h1f, 2);
		chk("frozen", 3'h7, h.q[1][6:4]);
		h.rd(8'h30, 1);
		chk("unmapped", 0, h.q[0]);
		$display("status done");
		gyr_pmu_status <= STFR_PMU_NORMAL;
		temp_sample <= {1'b0, 15'($urandom)};
		tk(25);
		rdw(8'h20, t);
		chk("temp", temp_sample, t);
		chk("valid", 1, temp_valid);
		gyr_pmu_status <= STFR_PMU_FASTUP;
		temp_sample <= 16'h8001;
		tk(55);
		rdw(8'h20, t);
		chk("slow", 16'h8001, t);
		chk("valid", 0, temp_valid);
		all_suspend <= 1'b1;
		tk(3);
		rdw(8'h20, t);
		chk("off", 16'h8000, t);
		all_suspend <= 1'b0;
		$display("temperature done");
		frame(3, 0);
		tk(3);
		frame(2, 3);
		tk(3);
		rdw(8'h22, t);
		chk("fill", 5, t);
		h.rd(8'h24, 2);
		chk("part", fb[1], h.q[1]);
		h.be();
		h.rd(8'h24, 6);
		fb.push_back(8'h80);
		for (int k = 0; k < 6; k++)
			chk("fifo", fb[k], h.q[k]);
		rdw(8'h22, t);
		chk("drained", 0, t);
		frame(3, 0);
		tk(3);
		h.wr(8'h7e, 8'h5a);
		rdw(8'h22, t);
		chk("keep", 3, t);
		h.wr(8'h7e, 8'ha5);
		rdw(8'h22, t);
		chk("flush", 0, t);
		// One frame past capacity is dropped and shows as the skip frame
		for (int k = 0; k < 1032; k++) begin
			fifo_wr_data <= 8'($urandom);
			fifo_wr_valid <= 1'b1;
			fifo_wr_last <= k[2:0] == 3'h7;
			tk(1);
		end
		fifo_wr_valid <= 1'b0;
		tk(3);
		chk("overflow", 1, fifo_overflow);
		rdw(8'h22, t);
		chk("full", 16'h0402, t);
		h.wr(8'h7e, 8'ha5);
		tk(1);
		chk("overflow", 0, fifo_overflow);
		$display("fifo done");
		print_verdict();
	end
	// Tests need about 1260 cycles
	initial begin
		#200000;
		fails++;
		print_verdict();
	end
endmodule : stfr_regs_tb
